/* File: design/fpt_consts.vh */
// Operation
// (R01) Erase clears a 1-KB block to ones
// (R02) Program ANDs one 32-bit word into flash
// (R03) One program and read bit per 2-KB
// (R04) Software loads MHz minus one before changes
// (R05) Reload resets to maximum clock value
// (R06) Program-enable zero blocks program and erase
// (R07) Read-enable zero allows instruction fetch only
// (R08) Both zero: execute-only block
// (R09) Program one, read zero: no data reads
// (R10) Program zero, read one: read-only block
// (R11) Both one: no restriction
// (R12) Protected data read gives bus fault
// (R13) Protected program sets violation, masked interrupt
// (R14) Protection bits reset to all ones
// (R15) Protection bits only clear, never set
// (R16) Uncommitted clears revert only on power-on
// (R17) Program or erase end sets complete
// (R18) Raw status ignores mask
// (R19) Write one clears raw and masked status
// (R20) Masked is raw AND mask; OR interrupt
// (R21) Fetches stall while operation runs
`ifndef FPT_CONSTS_VH
`define FPT_CONSTS_VH

`define FPT_OFS_ADDR       12'h000
`define FPT_OFS_DATA       12'h004
`define FPT_OFS_CMD        12'h008
`define FPT_OFS_RAW        12'h00C
`define FPT_OFS_MASK       12'h010
`define FPT_OFS_MISC       12'h014
`define FPT_OFS_RE0        12'h130
`define FPT_OFS_PE0        12'h134
`define FPT_OFS_USEC       12'h140
`define FPT_OFS_RE0_ALIAS  12'h200
`define FPT_OFS_RE1        12'h204
`define FPT_OFS_PE0_ALIAS  12'h400
`define FPT_OFS_PE1        12'h404

`define FPT_CMD_KEY        16'hA442
`define FPT_CMD_WRITE      0
`define FPT_CMD_ERASE      1
`define FPT_CMD_MERASE     2
`define FPT_CMD_COMMIT     3

`define FPT_ST_ACCESS      0
`define FPT_ST_PROG        1

`define FPT_RST_USEC       8'h31
`define FPT_RST_PROT0      32'hFFFFFFFF
`define FPT_RST_PROT1      16'hFFFF

`define FPT_NUM_WORDS      24576
`define FPT_LAST_WORD      15'h5FFF
`define FPT_TOP_BLOCK      6'h30
`define FPT_PROG_US        16'h0014
`define FPT_ERASE_US       16'h00C8

`endif

/* File: design/fpt_word_mem.v */
`timescale 1ns/100ps
module fpt_word_mem (
  input  wire        clk,
  input  wire        we,
  input  wire [14:0] waddr,
  input  wire [31:0] wdata,
  input  wire        re,
  input  wire [14:0] raddr,
  output reg  [31:0] rdata
);
`include "fpt_consts.vh"

  reg [31:0] mem [0:`FPT_NUM_WORDS-1];

  always @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    if (re) begin
      rdata <= mem[raddr];
    end
  end
endmodule

/* File: design/fpt_flash_ctrl.v */
`timescale 1ns/100ps
module fpt_flash_ctrl (
  input  wire        CLK_SYS,
  input  wire        RST,
  input  wire        POR,
  input  wire        HSEL,
  input  wire [31:0] HADDR,
  input  wire [1:0]  HTRANS,
  input  wire        HWRITE,
  input  wire [2:0]  HSIZE,
  input  wire [31:0] HWDATA,
  input  wire        HREADY,
  output reg  [31:0] HRDATA,
  output reg         HREADYOUT,
  output reg         HRESP,
  input  wire        RD_REQ,
  input  wire        RD_IFETCH,
  input  wire [16:0] RD_ADDR,
  output reg  [31:0] RD_DATA,
  output reg         RD_DONE,
  output reg         RD_FAULT,
  output reg         FLASH_BUSY,
  output reg         FLASH_INT
);
`include "fpt_consts.vh"

  localparam S_IDLE = 3'd0;
  localparam S_PRD  = 3'd1;
  localparam S_PWR  = 3'd2;
  localparam S_CLR  = 3'd3;
  localparam S_WAIT = 3'd4;

  reg  [2:0]  state_r;
  reg  [31:0] fma_r;
  reg  [31:0] fmd_r;
  reg  [3:0]  op_bits_r;
  reg  [1:0]  raw_r;
  reg  [1:0]  mask_r;
  reg  [7:0]  cycles_per_us_reload_r;
  reg  [7:0]  us_cnt_r;
  reg  [15:0] us_left_r;
  reg  [14:0] wptr_r;
  reg  [14:0] wlast_r;
  reg  [31:0] re0_r;
  reg  [15:0] re1_r;
  reg  [31:0] pe0_r;
  reg  [15:0] pe1_r;
  reg  [31:0] re0_nv_r = `FPT_RST_PROT0;
  reg  [15:0] re1_nv_r = `FPT_RST_PROT1;
  reg  [31:0] pe0_nv_r = `FPT_RST_PROT0;
  reg  [15:0] pe1_nv_r = `FPT_RST_PROT1;
  reg         reload_r;
  reg         dph_wr_r;
  reg  [11:0] dph_addr_r;
  reg         rd_stg_r;

  wire [47:0] block_read_enable_bits;
  wire [47:0] block_program_enable_bits;
  wire [1:0]  masked;
  wire        us_tick;
  wire        aph;
  wire [11:0] aofs;
  wire        cmd_wr;
  wire        key_ok;
  wire [5:0]  op_blk;
  wire        op_in_range;
  wire        op_blk_pe;
  wire        all_pe;
  wire        start_ok;
  wire        start_viol;
  wire        done_evt;
  wire [5:0]  rd_blk;
  wire        rd_in_range;
  wire        rd_allowed;
  wire        rd_accept;
  wire        rd_reject;
  wire [31:0] mem_rdata;
  reg         mem_we;
  reg  [14:0] mem_waddr;
  reg  [31:0] mem_wdata;
  reg         mem_re;
  reg  [14:0] mem_raddr;
  reg  [31:0] rd_mux;

  assign block_read_enable_bits    = {re1_r, re0_r}; // (R03)
  assign block_program_enable_bits = {pe1_r, pe0_r}; // (R03)
  assign masked = raw_r & mask_r; // (R20)

  // One-microsecond enable from the reload value
  assign us_tick = (us_cnt_r == 8'h00);

  assign aph    = HSEL && HTRANS[1] && HREADY;
  assign aofs   = HADDR[11:0];
  assign cmd_wr = dph_wr_r && (dph_addr_r == `FPT_OFS_CMD);
  assign key_ok = (HWDATA[31:16] == `FPT_CMD_KEY);

  assign op_blk      = fma_r[16:11];
  assign op_in_range = (fma_r[31:17] == 15'h0) && (op_blk < `FPT_TOP_BLOCK);
  assign op_blk_pe   = op_in_range && block_program_enable_bits[op_blk];
  assign all_pe      = &block_program_enable_bits;

  // Program-enable zero means the array is never touched
  assign start_ok = cmd_wr && key_ok && (state_r == S_IDLE) &&
                    ((HWDATA[`FPT_CMD_WRITE] && op_blk_pe) ||
                     (!HWDATA[`FPT_CMD_WRITE] && HWDATA[`FPT_CMD_ERASE] && op_blk_pe) ||
                     (!HWDATA[`FPT_CMD_WRITE] && !HWDATA[`FPT_CMD_ERASE] &&
                      HWDATA[`FPT_CMD_MERASE] && all_pe)); // (R06) (R08) (R10)
  assign start_viol = cmd_wr && key_ok && (state_r == S_IDLE) && !start_ok &&
                      (HWDATA[`FPT_CMD_WRITE] || HWDATA[`FPT_CMD_ERASE] ||
                       HWDATA[`FPT_CMD_MERASE]); // (R13)
  assign done_evt = (state_r == S_WAIT) && us_tick && (us_left_r == 16'h0000);

  assign rd_blk      = RD_ADDR[16:11];
  assign rd_in_range = (rd_blk < `FPT_TOP_BLOCK);
  // Instruction fetches pass regardless of the read bit
  assign rd_allowed  = rd_in_range &&
                       (RD_IFETCH || block_read_enable_bits[rd_blk]); // (R07) (R09) (R11)
  // Array is locked for the whole operation
  assign rd_accept = RD_REQ && (state_r == S_IDLE) && !rd_stg_r && !RD_DONE &&
                     !RD_FAULT && rd_allowed; // (R21)
  assign rd_reject = RD_REQ && (state_r == S_IDLE) && !rd_stg_r && !RD_DONE &&
                     !RD_FAULT && !rd_allowed; // (R12)

  always @* begin
    mem_we    = 1'b0;
    mem_waddr = wptr_r;
    mem_wdata = 32'hFFFFFFFF;
    mem_re    = 1'b0;
    mem_raddr = RD_ADDR[16:2];
    case (state_r)
      S_IDLE: begin
        mem_re = rd_accept;
      end
      S_PRD: begin
        mem_re    = 1'b1;
        mem_raddr = wptr_r;
      end
      S_PWR: begin
        mem_we    = 1'b1;
        mem_wdata = mem_rdata & fmd_r; // (R02)
      end
      S_CLR: begin
        mem_we = 1'b1; // (R01)
      end
      default: begin
        mem_we = 1'b0;
      end
    endcase
  end

  fpt_word_mem u_mem (
    .clk   (CLK_SYS),
    .we    (mem_we),
    .waddr (mem_waddr),
    .wdata (mem_wdata),
    .re    (mem_re),
    .raddr (mem_raddr),
    .rdata (mem_rdata)
  );

  always @* begin
    case (aofs)
      `FPT_OFS_ADDR:      rd_mux = fma_r;
      `FPT_OFS_DATA:      rd_mux = fmd_r;
      `FPT_OFS_CMD:       rd_mux = {28'h0000000, op_bits_r};
      `FPT_OFS_RAW:       rd_mux = {30'h0, raw_r}; // (R18)
      `FPT_OFS_MASK:      rd_mux = {30'h0, mask_r};
      `FPT_OFS_MISC:      rd_mux = {30'h0, masked};
      `FPT_OFS_RE0:       rd_mux = re0_r;
      `FPT_OFS_RE0_ALIAS: rd_mux = re0_r;
      `FPT_OFS_PE0:       rd_mux = pe0_r;
      `FPT_OFS_PE0_ALIAS: rd_mux = pe0_r;
      `FPT_OFS_RE1:       rd_mux = {16'h0000, re1_r};
      `FPT_OFS_PE1:       rd_mux = {16'h0000, pe1_r};
      `FPT_OFS_USEC:      rd_mux = {24'h000000, cycles_per_us_reload_r};
      default:            rd_mux = 32'h00000000;
    endcase
  end

  // Bus slave: zero wait, always OKAY
  always @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      HRDATA     <= 32'h00000000;
      HREADYOUT  <= 1'b1;
      HRESP      <= 1'b0;
      dph_wr_r   <= 1'b0;
      dph_addr_r <= 12'h000;
    end else begin
      dph_wr_r   <= aph && HWRITE;
      dph_addr_r <= aofs;
      if (aph && !HWRITE) begin
        HRDATA <= rd_mux;
      end
    end
  end

  // Software registers and status
  always @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      fma_r                  <= 32'h00000000;
      fmd_r                  <= 32'h00000000;
      mask_r                 <= 2'b00;
      raw_r                  <= 2'b00;
      cycles_per_us_reload_r <= `FPT_RST_USEC; // (R05)
      FLASH_INT              <= 1'b0;
    end else begin
      if (dph_wr_r && dph_addr_r == `FPT_OFS_ADDR) begin
        fma_r <= HWDATA;
      end
      if (dph_wr_r && dph_addr_r == `FPT_OFS_DATA) begin
        fmd_r <= HWDATA;
      end
      if (dph_wr_r && dph_addr_r == `FPT_OFS_MASK) begin
        mask_r <= HWDATA[1:0];
      end
      // Takes effect at next microsecond reload
      if (dph_wr_r && dph_addr_r == `FPT_OFS_USEC) begin
        cycles_per_us_reload_r <= HWDATA[7:0]; // (R04)
      end
      // Set wins over a same-cycle clear
      raw_r[`FPT_ST_ACCESS] <= start_viol ||
        (raw_r[`FPT_ST_ACCESS] && !(dph_wr_r && dph_addr_r == `FPT_OFS_MISC &&
         HWDATA[`FPT_ST_ACCESS])); // (R13) (R19)
      raw_r[`FPT_ST_PROG] <= done_evt ||
        (raw_r[`FPT_ST_PROG] && !(dph_wr_r && dph_addr_r == `FPT_OFS_MISC &&
         HWDATA[`FPT_ST_PROG])); // (R17) (R19)
      FLASH_INT <= |masked; // (R20)
    end
  end

  // Operation sequencer
  always @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      state_r    <= S_IDLE;
      op_bits_r  <= 4'h0;
      us_cnt_r   <= 8'h00;
      us_left_r  <= 16'h0000;
      wptr_r     <= 15'h0000;
      wlast_r    <= 15'h0000;
      FLASH_BUSY <= 1'b0;
    end else begin
      us_cnt_r <= us_tick ? cycles_per_us_reload_r : us_cnt_r - 8'h01;
      case (state_r)
        S_IDLE: begin
          if (start_ok) begin
            FLASH_BUSY <= 1'b1;
            if (HWDATA[`FPT_CMD_WRITE]) begin
              op_bits_r <= 4'h1;
              wptr_r    <= fma_r[16:2];
              state_r   <= S_PRD;
            end else if (HWDATA[`FPT_CMD_ERASE]) begin
              op_bits_r <= 4'h2;
              wptr_r    <= {fma_r[16:10], 8'h00};
              wlast_r   <= {fma_r[16:10], 8'hFF}; // (R01)
              state_r   <= S_CLR;
            end else begin
              op_bits_r <= 4'h4;
              wptr_r    <= 15'h0000;
              wlast_r   <= `FPT_LAST_WORD;
              state_r   <= S_CLR;
            end
          end
        end
        S_PRD: begin
          state_r <= S_PWR;
        end
        S_PWR: begin
          us_left_r <= `FPT_PROG_US;
          state_r   <= S_WAIT;
        end
        S_CLR: begin
          wptr_r <= wptr_r + 15'h0001;
          if (wptr_r == wlast_r) begin
            us_left_r <= `FPT_ERASE_US;
            state_r   <= S_WAIT;
          end
        end
        S_WAIT: begin
          if (us_tick) begin
            if (us_left_r == 16'h0000) begin
              op_bits_r  <= 4'h0;
              FLASH_BUSY <= 1'b0;
              state_r    <= S_IDLE;
            end else begin
              us_left_r <= us_left_r - 16'h0001;
            end
          end
        end
        default: begin
          state_r <= S_IDLE;
        end
      endcase
    end
  end

  // Data read port
  always @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      rd_stg_r <= 1'b0;
      RD_DATA  <= 32'h00000000;
      RD_DONE  <= 1'b0;
      RD_FAULT <= 1'b0;
    end else begin
      rd_stg_r <= rd_accept;
      RD_DONE  <= rd_stg_r;
      RD_FAULT <= rd_reject; // (R12)
      if (rd_stg_r) begin
        RD_DATA <= mem_rdata;
      end
    end
  end

  // Protection bits live on power-on reset only
  always @(posedge CLK_SYS or posedge POR) begin
    if (POR) begin
      re0_r    <= `FPT_RST_PROT0; // (R14)
      re1_r    <= `FPT_RST_PROT1;
      pe0_r    <= `FPT_RST_PROT0;
      pe1_r    <= `FPT_RST_PROT1;
      reload_r <= 1'b1;
    end else begin
      reload_r <= 1'b0;
      if (reload_r) begin
        re0_r <= re0_nv_r; // (R16)
        re1_r <= re1_nv_r;
        pe0_r <= pe0_nv_r;
        pe1_r <= pe1_nv_r;
      end else if (dph_wr_r) begin
        if (dph_addr_r == `FPT_OFS_RE0 || dph_addr_r == `FPT_OFS_RE0_ALIAS) begin
          re0_r <= re0_r & HWDATA; // (R15)
        end
        if (dph_addr_r == `FPT_OFS_PE0 || dph_addr_r == `FPT_OFS_PE0_ALIAS) begin
          pe0_r <= pe0_r & HWDATA; // (R15)
        end
        if (dph_addr_r == `FPT_OFS_RE1) begin
          re1_r <= re1_r & HWDATA[15:0]; // (R15)
        end
        if (dph_addr_r == `FPT_OFS_PE1) begin
          pe1_r <= pe1_r & HWDATA[15:0]; // (R15)
        end
      end
    end
  end

  // Stored copy stands for nonvolatile cells, so no reset may touch it
  always @(posedge CLK_SYS) begin
    if (cmd_wr && key_ok && HWDATA[`FPT_CMD_COMMIT] && state_r == S_IDLE &&
        fma_r[31:2] == 30'h0) begin
      case (fma_r[1:0])
        2'b00:   re0_nv_r <= re0_nv_r & re0_r; // (R16)
        2'b01:   pe0_nv_r <= pe0_nv_r & pe0_r;
        2'b10:   re1_nv_r <= re1_nv_r & re1_r;
        default: pe1_nv_r <= pe1_nv_r & pe1_r;
      endcase
    end
  end
endmodule

/* File: verif/fpt_flash_ctrl_checker.sv */
`timescale 1ns/100ps
module fpt_flash_ctrl_checker (
  input wire logic        CLK_SYS,
  input wire logic        RST,
  input wire logic        HSEL,
  input wire logic [1:0]  HTRANS,
  input wire logic        HWRITE,
  input wire logic        HREADY,
  input wire logic [31:0] HRDATA,
  input wire logic        HREADYOUT,
  input wire logic        HRESP,
  input wire logic        RD_REQ,
  input wire logic [31:0] RD_DATA,
  input wire logic        RD_DONE,
  input wire logic        RD_FAULT,
  input wire logic        FLASH_BUSY
);
  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (RST);

  a_bus_okay: assert property (HREADYOUT && !HRESP)
    else $error("bus slave stalled or answered with an error");
  a_done_stalled: assert property (RD_DONE |-> !$past(FLASH_BUSY, 2))
    else $error("read completed while a flash operation ran");
  a_fault_stalled: assert property (RD_FAULT |-> !$past(FLASH_BUSY))
    else $error("read faulted while a flash operation ran");
  a_answer_once: assert property ((RD_DONE || RD_FAULT) |=> !RD_DONE && !RD_FAULT)
    else $error("read answer longer than one cycle");
  a_answer_single: assert property (!(RD_DONE && RD_FAULT))
    else $error("read both completed and faulted");
  a_answer_prompt: assert property ($rose(RD_REQ) && !FLASH_BUSY |->
    ##[1:2] (RD_DONE || RD_FAULT))
    else $error("idle read not answered in two cycles");
  a_rdata_held: assert property (!$stable(RD_DATA) |-> RD_DONE)
    else $error("read data changed without a completed read");
  a_hrdata_held: assert property (!$past(HSEL && HTRANS[1] && !HWRITE && HREADY)
    |-> $stable(HRDATA))
    else $error("bus read data changed without a read");
  a_busy_minimum: assert property ($rose(FLASH_BUSY) |-> FLASH_BUSY [*8])
    else $error("flash operation ended too early");

  // Main scenarios reached
  c_fault: cover property (RD_FAULT);
  c_stall: cover property (RD_REQ && FLASH_BUSY);
  c_op_end: cover property ($fell(FLASH_BUSY));
endmodule

bind fpt_flash_ctrl fpt_flash_ctrl_checker u_chk (
  .CLK_SYS(CLK_SYS), .RST(RST), .HSEL(HSEL), .HTRANS(HTRANS), .HWRITE(HWRITE),
  .HREADY(HREADY), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP),
  .RD_REQ(RD_REQ), .RD_DATA(RD_DATA), .RD_DONE(RD_DONE), .RD_FAULT(RD_FAULT),
  .FLASH_BUSY(FLASH_BUSY)
);

/* File: verif/fpt_fetch_master.sv */
`timescale 1ns/100ps
module fpt_fetch_master (
  input  wire         clk,
  input  wire         rd_done,
  input  wire         rd_fault,
  input  wire  [31:0] rd_data,
  output logic        rd_req,
  output logic        rd_ifetch,
  output logic [16:0] rd_addr
);
  initial begin
    rd_req = 1'b0;
    rd_ifetch = 1'b1;
    rd_addr = 17'h1FFFF;
  end

  // Starts one edge late so a released request never meets a new one in one step
  task automatic fetch(input logic ifetch, input logic [16:0] a,
                       output logic [31:0] d, output logic flt);
    @(posedge clk);
    rd_req <= 1'b1;
    rd_ifetch <= ifetch;
    rd_addr <= a;
    do @(posedge clk); while (rd_done !== 1'b1 && rd_fault !== 1'b1);
    d = rd_data;
    flt = rd_fault;
    rd_req <= 1'b0;
    // Released lines show the inverse, not a stale copy
    rd_ifetch <= ~ifetch;
    rd_addr <= ~a;
  endtask
endmodule

/* File: verif/flash_protect_timing_ctrl_tb_top.sv */
`timescale 1ns/100ps
`include "fpt_consts.vh"
module flash_protect_timing_ctrl_tb_top;
  logic        clk, rst, por, hsel, hwrite, f;
  logic [1:0]  htrans;
  logic [31:0] haddr, hwdata, d;
  wire  [31:0] hrdata, rd_data;
  wire  [16:0] rd_addr;
  wire         hready, hresp, rd_req, rd_if, rd_done, rd_fault, busy, f_int;
  int          failures, n_checks, cyc;

  fpt_flash_ctrl u_dut (
    .CLK_SYS(clk), .RST(rst), .POR(por), .HSEL(hsel), .HADDR(haddr),
    .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata),
    .HREADY(hready), .HRDATA(hrdata), .HREADYOUT(hready), .HRESP(hresp),
    .RD_REQ(rd_req), .RD_IFETCH(rd_if), .RD_ADDR(rd_addr), .RD_DATA(rd_data),
    .RD_DONE(rd_done), .RD_FAULT(rd_fault), .FLASH_BUSY(busy), .FLASH_INT(f_int)
  );
  fpt_fetch_master u_fm (
    .clk(clk), .rd_done(rd_done), .rd_fault(rd_fault), .rd_data(rd_data),
    .rd_req(rd_req), .rd_ifetch(rd_if), .rd_addr(rd_addr)
  );

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic give_verdict;
    if (failures == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // Mass erase alone needs about 25000 cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      failures++;
      give_verdict();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                     output logic [31:0] q);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {20'h00000, a};
    do @(posedge clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk); while (hready !== 1'b1);
    q = hrdata;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] wd);
    logic [31:0] q;
    bus(1'b1, a, wd, q);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h00000000, q);
    chk(q, e);
  endtask

  // Busy two cycles after the command must equal e; then wait for busy to fall
  task automatic run(input logic [15:0] c, input logic e);
    wr(`FPT_OFS_CMD, {`FPT_CMD_KEY, c});
    repeat (2) @(posedge clk);
    chk({31'h0, busy}, {31'h0, e});
    while (busy === 1'b1) @(posedge clk);
  endtask

  initial begin
    {rst, por, hsel, hwrite, htrans, haddr, hwdata} = {2'h3, 68'h0};
    {failures, n_checks, cyc} = 0;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    por <= 1'b0;
    @(posedge clk);
    rd(`FPT_OFS_USEC, 32'h00000031);
    rd(`FPT_OFS_PE0_ALIAS, `FPT_RST_PROT0);
    rd(`FPT_OFS_RE1, {16'h0000, `FPT_RST_PROT1});
    rd(12'hFFC, 32'h00000000);
    wr(`FPT_OFS_USEC, 32'h00000000);
    run(16'h0004, 1'b1);
    u_fm.fetch(1'b0, 17'h17FFC, d, f);
    chk(d, 32'hFFFFFFFF);
    wr(`FPT_OFS_ADDR, 32'h00000000);
    run(16'h0002, 1'b1);
    rd(`FPT_OFS_RAW, 32'h00000002);
    wr(`FPT_OFS_MISC, 32'h00000002);
    rd(`FPT_OFS_RAW, 32'h00000000);
    u_fm.fetch(1'b0, 17'h00000, d, f);
    chk(d, 32'hFFFFFFFF);
    wr(`FPT_OFS_DATA, 32'h12345678);
    run(16'h0001, 1'b1);
    wr(`FPT_OFS_DATA, 32'hFFFF00FF);
    run(16'h0001, 1'b1);
    u_fm.fetch(1'b0, 17'h00000, d, f);
    chk(d, 32'h12340078);
    wr(`FPT_OFS_DATA, 32'h5A5A5A5A);
    wr(`FPT_OFS_ADDR, 32'h00000004);
    wr(`FPT_OFS_CMD, {`FPT_CMD_KEY, 16'h0001});
    u_fm.fetch(1'b1, 17'h00004, d, f);
    chk(d, 32'h5A5A5A5A);
    wr(`FPT_OFS_MISC, 32'h00000003);
    wr(`FPT_OFS_PE0, 32'hFFFFFFFE);
    wr(`FPT_OFS_PE0, 32'hFFFFFFFF);
    rd(`FPT_OFS_PE0, 32'hFFFFFFFE);
    wr(`FPT_OFS_MASK, 32'h00000001);
    run(16'h0001, 1'b0);
    rd(`FPT_OFS_RAW, 32'h00000001);
    chk({31'h0, f_int}, 32'h00000001);
    rd(`FPT_OFS_MISC, 32'h00000001);
    wr(`FPT_OFS_MISC, 32'h00000001);
    rd(`FPT_OFS_RAW, 32'h00000000);
    chk({31'h0, f_int}, 32'h00000000);
    run(16'h0004, 1'b0);
    wr(`FPT_OFS_RE0_ALIAS, 32'hFFFFFFFC);
    u_fm.fetch(1'b0, 17'h00000, d, f);
    chk({31'h0, f}, 32'h00000001);
    u_fm.fetch(1'b1, 17'h00000, d, f);
    chk(d, 32'h12340078);
    wr(`FPT_OFS_ADDR, 32'h00000800);
    run(16'h0002, 1'b1);
    u_fm.fetch(1'b0, 17'h00800, d, f);
    chk({31'h0, f}, 32'h00000001);
    wr(`FPT_OFS_PE0, 32'hFFFFFFFA);
    wr(`FPT_OFS_ADDR, 32'h00001000);
    run(16'h0002, 1'b0);
    u_fm.fetch(1'b0, 17'h01000, d, f);
    chk({31'h0, f}, 32'h00000000);
    chk(d, 32'hFFFFFFFF);
    wr(`FPT_OFS_ADDR, 32'h00000001);
    run(16'h0008, 1'b0);
    wr(`FPT_OFS_PE0, 32'hFFFFFFF0);
    rst <= 1'b1;
    @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(`FPT_OFS_PE0, 32'hFFFFFFF0);
    por <= 1'b1;
    @(posedge clk);
    por <= 1'b0;
    @(posedge clk);
    rd(`FPT_OFS_PE0, 32'hFFFFFFFA);
    rd(`FPT_OFS_RE0, `FPT_RST_PROT0);
    give_verdict();
  end
endmodule
